// ===== can_node_pkg.sv
// Shared constants and types of the CAN node configuration block
package can_node_pkg;
  // Avalon-MM slave geometry
  localparam int DW = 32;
  localparam int AW = 6;
  localparam int BEW = DW / 8;
  // Register byte offsets
  localparam logic [AW-1:0] OFF_CTRL = 6'h00;
  localparam logic [AW-1:0] OFF_STATION = 6'h04;
  localparam logic [AW-1:0] OFF_RATE = 6'h08;
  localparam logic [AW-1:0] OFF_ROLE = 6'h0c;
  localparam logic [AW-1:0] OFF_NET = 6'h10;
  localparam logic [AW-1:0] OFF_STATUS = 6'h14;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 6'h18;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 6'h1c;
  localparam logic [AW-1:0] OFF_TS_ONE = 6'h20;
  localparam logic [AW-1:0] OFF_TS_TWO = 6'h24;
  localparam logic [AW-1:0] OFF_TIME = 6'h28;
  // Control register layout, bits 3:0; bit 4 is the init strobe
  typedef struct packed {
    logic fast_in_en;
    logic error_mode;
    logic sync_link_en;
    logic cycle_ind_en;
  } ctrl_s;
  localparam int CTRL_W = 4;
  localparam int CTRL_INIT_BIT = 4;
  localparam ctrl_s CTRL_RST = 4'h0;
  // Station address
  localparam logic [7:0] ADDR_MAX = 8'h7f;
  localparam logic [6:0] SLAVE_ADDR_MIN = 7'h02;
  localparam logic [6:0] MASTER_ADDR = 7'h01;
  localparam logic [6:0] STATION_RST = 7'h05;
  // Bit rates in kbit/s
  localparam logic [15:0] RATE_1000 = 16'h03e8;
  localparam logic [15:0] RATE_500 = 16'h01f4;
  localparam logic [15:0] RATE_250 = 16'h00fa;
  localparam logic [15:0] RATE_125 = 16'h007d;
  localparam logic [15:0] RATE_50 = 16'h0032;
  localparam logic [15:0] RATE_20 = 16'h0014;
  localparam logic [15:0] RATE_10 = 16'h000a;
  localparam logic [15:0] RATE_DEFAULT = RATE_20;
  // Bus role
  localparam int ROLE_MASTER_BIT = 1;
  localparam logic [15:0] ROLE_RST = 16'h0000;
  // Network state, flash count is state plus one
  typedef enum logic [1:0] {
    NET_INIT = 2'h0,
    NET_PREOP = 2'h1,
    NET_STOPPED = 2'h2,
    NET_OPER = 2'h3
  } net_state_e;
  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_FAST_ONE = 0;
  localparam int IRQ_FAST_TWO = 1;
  localparam int IRQ_SYNC = 2;
  localparam int IRQ_INIT = 3;
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  localparam int FLASH_PERIOD_S = 2;
  localparam int FLASH_PERIOD_MS = FLASH_PERIOD_S * MS_PER_S;
  localparam int TX_PULSE_MS = 50;
  localparam int FLASH_ON_MS = 200;
  localparam int FLASH_OFF_MS = 200;
  localparam int FAST_LAT_NS = 200;
  localparam int FAST_LAT_CYC = FAST_LAT_NS / CLK_PERIOD_NS;
endpackage : can_node_pkg

// ===== pin_sync.sv
// Two-flop synchroniser with change and rise detection
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Asynchronous pins
  input wire logic [W-1:0] i_pin,
  // Synchronised view
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_change,
  output logic [W-1:0] o_rise
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  // First stage is read only by the second
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign o_level = sync_r;
  assign o_change = sync_r ^ last_r;
  assign o_rise = sync_r & ~last_r;
endmodule : pin_sync

// ===== status_flasher.sv
// Green status flash groups with message activity pulses
module status_flasher
  import can_node_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Control
  input wire logic i_tick_ms,
  input wire logic i_en,
  input wire logic [2:0] i_count,
  input wire logic i_tx_evt,
  // Indicator
  output logic o_led
);
  typedef enum logic [2:0] {
    FL_IDLE = 3'b000,
    FL_ON = 3'b001,
    FL_OFF = 3'b011,
    FL_GAP = 3'b010,
    FL_PULSE = 3'b110
  } fl_state_e;

  localparam logic [10:0] PER_LAST = 11'(FLASH_PERIOD_MS - 1);
  localparam logic [10:0] ON_LAST = 11'(FLASH_ON_MS - 1);
  localparam logic [10:0] OFF_LAST = 11'(FLASH_OFF_MS - 1);
  localparam logic [10:0] PULSE_LAST = 11'(TX_PULSE_MS - 1);
  // Pulse plus its dark tail must end before the next group
  localparam logic [10:0] PULSE_LIMIT =
    11'(FLASH_PERIOD_MS - TX_PULSE_MS - FLASH_OFF_MS);

  fl_state_e state_r;
  logic [10:0] per_r;
  logic [10:0] tm_r;
  logic [2:0] left_r;
  logic pend_r;
  logic take;

  assign take = (state_r == FL_GAP) && pend_r && (per_r < PULSE_LIMIT);

  // Group period counter, one group every period
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      per_r <= '0;
    end else if (!i_en || state_r == FL_IDLE) begin
      // Period restarts with the first group after enable
      per_r <= '0;
    end else if (i_tick_ms) begin
      per_r <= (per_r == PER_LAST) ? 11'h000 : per_r + 11'h001;
    end
  end

  // Pending activity, a new event wins over the consume
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= i_tx_evt | (pend_r & ~take);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= FL_IDLE;
      tm_r <= '0;
      left_r <= '0;
    end else if (!i_en) begin
      state_r <= FL_IDLE;
      tm_r <= '0;
    end else begin
      case (state_r)
        FL_IDLE: begin
          state_r <= FL_ON;
          tm_r <= '0;
          left_r <= i_count;
        end
        FL_ON: begin
          if (i_tick_ms) begin
            tm_r <= tm_r + 11'h001;
            if (tm_r == ON_LAST) begin
              state_r <= FL_OFF;
              tm_r <= '0;
              left_r <= left_r - 3'h1;
            end
          end
        end
        FL_OFF: begin
          if (i_tick_ms) begin
            tm_r <= tm_r + 11'h001;
            if (tm_r == OFF_LAST) begin
              tm_r <= '0;
              state_r <= (left_r == 3'h0) ? FL_GAP : FL_ON;
            end
          end
        end
        FL_GAP: begin
          // Long dark gap keeps the count readable
          if (i_tick_ms && per_r == PER_LAST) begin
            state_r <= FL_ON;
            tm_r <= '0;
            left_r <= i_count;
          end else if (take) begin
            state_r <= FL_PULSE;
            tm_r <= '0;
          end
        end
        FL_PULSE: begin
          if (i_tick_ms) begin
            tm_r <= tm_r + 11'h001;
            if (tm_r == PULSE_LAST) begin
              state_r <= FL_OFF;
              tm_r <= '0;
            end
          end
        end
        default: begin
          state_r <= FL_IDLE;
        end
      endcase
    end
  end

  assign o_led = (state_r == FL_ON) || (state_r == FL_PULSE);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  chk_pulse_len: assert property (
    (state_r == FL_PULSE) |-> (tm_r <= PULSE_LAST))
    else $error("activity pulse too long");
  chk_group_gap: assert property (
    $rose(state_r == FL_ON) && left_r == i_count |-> per_r == 11'h000 || !$past(i_en))
    else $error("flash group started off period");
endmodule : status_flasher

// ===== can_node_config_status.sv
// CAN node configuration, LED status and fast input capture
//
// Function
// - Station address from switches, accepted value 1 to 127.
// - Switch address copied into station address parameter at bus init.
// - Low switch gives low nibble, high switch gives high nibble.
// - Both switches zero keeps the stored station address parameter.
// - Slaves use addresses 2 to 127; address 1 only for master.
// - Red indicator lit whenever the node is in error mode.
// - Cycle indication: green off at cycle start, on at cycle end.
// - Without cycle indication, with sync link, green group every 2 s.
// - Flash count gives state: 1 init, 2 preop, 3 stopped, 4 operational.
// - Between groups, 50 ms green pulses show message transmission.
// - Bus role bit 1 clear is slave, set is master; 2h is master.
// - Only 1000, 500, 250, 125, 50, 20, 10 kbit/s accepted.
// - Unsupported bit rate written falls back to 20 kbit/s.
// - All stations share cycle time settings and bit rate.
// - Fast inputs registered in real time within 200 ns when enabled.
module can_node_config_status
  import can_node_pkg::*;
#(
  parameter int CYC_PER_MS = CYCLES_PER_MS,
  parameter logic [6:0] STATION_DEFAULT = STATION_RST
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Avalon-MM slave
  input wire logic [can_node_pkg::AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [can_node_pkg::DW-1:0] i_avs_writedata,
  input wire logic [can_node_pkg::BEW-1:0] i_avs_byteenable,
  output logic [can_node_pkg::DW-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  // Front panel pins
  input wire logic [3:0] i_address_switch_low,
  input wire logic [3:0] i_address_switch_high,
  input wire logic i_fast_input_one,
  input wire logic i_fast_input_two,
  input wire logic i_sync_clk,
  output logic o_led_red,
  output logic o_led_green,
  // Controller and CAN core events
  input wire logic i_cycle_start,
  input wire logic i_cycle_end,
  input wire logic i_msg_tx,
  // Effective configuration
  output logic [6:0] o_station_addr,
  output logic [15:0] o_bit_rate,
  output logic o_master,
  output logic o_addr_fault
);
  localparam int fast_lat_cyc = FAST_LAT_CYC;

  function automatic logic [DW-1:0] merge(
    input logic [DW-1:0] old,
    input logic [DW-1:0] wd,
    input logic [BEW-1:0] be
  );
    logic [DW-1:0] res;
    res = old;
    for (int i = 0; i < BEW; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic rate_ok(input logic [15:0] v);
    return v == RATE_1000 || v == RATE_500 || v == RATE_250 ||
      v == RATE_125 || v == RATE_50 || v == RATE_20 || v == RATE_10;
  endfunction : rate_ok

  ctrl_s ctrl_r;
  logic [6:0] station_r;
  logic [15:0] rate_r;
  logic [15:0] role_r;
  net_state_e net_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [31:0] time_r;
  logic [31:0] ts_one_r;
  logic [31:0] ts_two_r;
  logic [DW-1:0] rdata_r;
  logic ack_r;
  logic red_r;
  logic green_r;
  logic fault_r;
  logic [31:0] div_r;
  logic tick_ms;
  logic flash_led;
  logic [7:0] sw_s;
  logic [2:0] ev_change;
  logic [2:0] ev_rise;
  logic [2:0] ev_level;
  logic req;
  logic wr_en;
  logic [DW-1:0] wmerged;
  logic bus_init;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] w1c;
  logic [15:0] rate_wr;

  // Pins from outside the clock domain
  pin_sync #(.W(8)) u_sw_sync (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_pin({i_address_switch_high, i_address_switch_low}),
    .o_level(sw_s),
    .o_change(),
    .o_rise()
  );

  pin_sync #(.W(3)) u_ev_sync (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_pin({i_sync_clk, i_fast_input_two, i_fast_input_one}),
    .o_level(ev_level),
    .o_change(ev_change),
    .o_rise(ev_rise)
  );

  // Bus handshake: one wait state, then the answer
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_r;
  assign wr_en = i_avs_write & ack_r;
  assign o_avs_readdata = rdata_r;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= '0;
    end else if (i_avs_read && !ack_r) begin
      if (i_avs_address == OFF_CTRL) begin
        rdata_r <= DW'(ctrl_r);
      end else if (i_avs_address == OFF_STATION) begin
        rdata_r <= DW'(station_r);
      end else if (i_avs_address == OFF_RATE) begin
        rdata_r <= DW'(rate_r);
      end else if (i_avs_address == OFF_ROLE) begin
        rdata_r <= DW'(role_r);
      end else if (i_avs_address == OFF_NET) begin
        rdata_r <= DW'(net_r);
      end else if (i_avs_address == OFF_STATUS) begin
        rdata_r <= DW'({ev_level, fault_r, o_master, sw_s, 1'b0, station_r});
      end else if (i_avs_address == OFF_IRQ_STAT) begin
        rdata_r <= DW'(irq_stat_r);
      end else if (i_avs_address == OFF_IRQ_MASK) begin
        rdata_r <= DW'(irq_mask_r);
      end else if (i_avs_address == OFF_TS_ONE) begin
        rdata_r <= ts_one_r;
      end else if (i_avs_address == OFF_TS_TWO) begin
        rdata_r <= ts_two_r;
      end else if (i_avs_address == OFF_TIME) begin
        rdata_r <= time_r;
      end else begin
        rdata_r <= '0;
      end
    end
  end

  assign wmerged = merge('0, i_avs_writedata, i_avs_byteenable);
  assign bus_init = wr_en && i_avs_address == OFF_CTRL && wmerged[CTRL_INIT_BIT];

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= CTRL_RST;
      irq_mask_r <= '0;
      net_r <= NET_INIT;
    end else if (wr_en) begin
      if (i_avs_address == OFF_CTRL) begin
        ctrl_r <= ctrl_s'(merge(DW'(ctrl_r), i_avs_writedata,
          i_avs_byteenable));
      end else if (i_avs_address == OFF_IRQ_MASK) begin
        irq_mask_r <= IRQ_W'(merge(DW'(irq_mask_r), i_avs_writedata,
          i_avs_byteenable));
      end else if (i_avs_address == OFF_NET) begin
        net_r <= net_state_e'(merge(DW'(net_r), i_avs_writedata,
          i_avs_byteenable));
      end
    end
  end

  // Address taken from switches only at bus init; out of range is ignored
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      station_r <= STATION_DEFAULT;
    end else if (wr_en && i_avs_address == OFF_STATION) begin
      station_r <= 7'(merge(DW'(station_r), i_avs_writedata, i_avs_byteenable));
    end else if (bus_init && sw_s != 8'h00 && sw_s <= ADDR_MAX) begin
      station_r <= sw_s[6:0];
    end
  end

  // Rate shared by all stations; software keeps them equal
  assign rate_wr = 16'(merge(DW'(rate_r), i_avs_writedata, i_avs_byteenable));

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rate_r <= RATE_DEFAULT;
      role_r <= ROLE_RST;
    end else if (wr_en && i_avs_address == OFF_RATE) begin
      rate_r <= rate_ok(rate_wr) ? rate_wr : RATE_DEFAULT;
    end else if (wr_en && i_avs_address == OFF_ROLE) begin
      role_r <= 16'(merge(DW'(role_r), i_avs_writedata, i_avs_byteenable));
    end
  end

  assign o_master = role_r[ROLE_MASTER_BIT];
  assign o_station_addr = station_r;
  assign o_bit_rate = rate_r;
  assign o_addr_fault = fault_r;

  // Flag a role and address pair that breaks the bus addressing plan
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= o_master ? (station_r != MASTER_ADDR)
        : (station_r < SLAVE_ADDR_MIN);
    end
  end

  // Free running time base for the input timestamps
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      time_r <= '0;
    end else begin
      time_r <= time_r + 32'h0000_0001;
    end
  end

  // Capture one clock after the two sync stages, well under the bound
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ts_one_r <= '0;
      ts_two_r <= '0;
    end else if (ctrl_r.fast_in_en) begin
      if (ev_change[0]) begin
        ts_one_r <= time_r;
      end
      if (ev_change[1]) begin
        ts_two_r <= time_r;
      end
    end
  end

  assign irq_ev[IRQ_FAST_ONE] = ctrl_r.fast_in_en & ev_change[0];
  assign irq_ev[IRQ_FAST_TWO] = ctrl_r.fast_in_en & ev_change[1];
  assign irq_ev[IRQ_SYNC] = ev_rise[2];
  assign irq_ev[IRQ_INIT] = bus_init;
  assign w1c = (wr_en && i_avs_address == OFF_IRQ_STAT) ? IRQ_W'(wmerged) : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_ev | (irq_stat_r & ~w1c);
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  // Millisecond enable for the indicator timing
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_r <= '0;
    end else begin
      div_r <= (div_r == 32'(CYC_PER_MS - 1)) ? 32'h0 : div_r + 32'h1;
    end
  end

  assign tick_ms = (div_r == 32'(CYC_PER_MS - 1));

  status_flasher u_flasher (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_tick_ms(tick_ms),
    .i_en(!ctrl_r.cycle_ind_en && ctrl_r.sync_link_en),
    .i_count(3'(net_r) + 3'h1),
    .i_tx_evt(i_msg_tx),
    .o_led(flash_led)
  );

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      red_r <= 1'b0;
      green_r <= 1'b0;
    end else begin
      red_r <= ctrl_r.error_mode;
      if (ctrl_r.cycle_ind_en) begin
        if (i_cycle_end) begin
          green_r <= 1'b1;
        end else if (i_cycle_start) begin
          green_r <= 1'b0;
        end
      end else if (ctrl_r.sync_link_en) begin
        green_r <= flash_led;
      end else begin
        green_r <= 1'b0;
      end
    end
  end

  assign o_led_red = red_r;
  assign o_led_green = green_r;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_init_sw;
    bus_init && sw_s != 8'h00 && sw_s <= ADDR_MAX;
  endsequence

  sequence s_fast_one;
    ctrl_r.fast_in_en && $changed(i_fast_input_one);
  endsequence

  chk_addr_copy: assert property (
    s_init_sw |=> o_station_addr == $past(sw_s[6:0]))
    else $error("switch address not adopted");
  chk_nibble_order: assert property (
    s_init_sw |=> o_station_addr[3:0] == $past(i_address_switch_low, 3))
    else $error("low switch not in low nibble");
  chk_zero_keeps: assert property (
    bus_init && sw_s == 8'h00 |=> $stable(o_station_addr))
    else $error("zero switches changed address");
  chk_addr_range: assert property (
    bus_init && sw_s > ADDR_MAX |=> $stable(o_station_addr))
    else $error("out of range switch value adopted");
  chk_slave_addr: assert property (
    !o_master && o_station_addr < SLAVE_ADDR_MIN ##1 $stable(o_station_addr)
      && !o_master |-> o_addr_fault)
    else $error("slave on reserved address not flagged");
  chk_red_error: assert property (
    ctrl_r.error_mode [*2] |-> o_led_red)
    else $error("red off in error mode");
  chk_cycle_led: assert property (
    ctrl_r.cycle_ind_en && i_cycle_start && !i_cycle_end |=> !o_led_green)
    else $error("green on at cycle start");
  chk_master_role: assert property (
    wr_en && i_avs_address == OFF_ROLE && i_avs_byteenable[0]
      |=> o_master == $past(i_avs_writedata[ROLE_MASTER_BIT]))
    else $error("role bit not followed");
  chk_rate_default: assert property (
    wr_en && i_avs_address == OFF_RATE && !rate_ok(rate_wr)
      |=> o_bit_rate == RATE_DEFAULT)
    else $error("invalid rate not defaulted");
  chk_fast_capture: assert property (
    s_fast_one ##1 ctrl_r.fast_in_en [*3] |-> ##[0:fast_lat_cyc] irq_stat_r[IRQ_FAST_ONE])
    else $error("fast input edge not registered in time");
endmodule : can_node_config_status

// ===== can_station_model.sv
// Far station model driving the hardware sync clock line
module can_station_model (
  // Sync clock line
  output logic o_sync_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_sync_clk = 1'b0;
  // Same link rate as every station; the line rests low between frames
  task automatic burst(input int n);
    #3;
    repeat (n) begin
      #40 o_sync_clk = 1'b1;
      #40 o_sync_clk = 1'b0;
    end
  endtask : burst
endmodule : can_station_model

// ===== can_node_config_status_bench.sv
// Self-checking bench for the CAN node configuration block
module can_node_config_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import can_node_pkg::*;
  logic i_core_clk, i_arst_n, i_avs_read, i_avs_write, o_avs_waitrequest, o_irq;
  logic [AW-1:0] i_avs_address;
  logic [DW-1:0] i_avs_writedata, o_avs_readdata;
  logic [BEW-1:0] i_avs_byteenable;
  logic i_fast_input_one, i_fast_input_two, i_sync_clk, o_led_red, o_led_green;
  logic i_cycle_start, i_cycle_end, i_msg_tx, o_master, o_addr_fault, g;
  logic [3:0] i_address_switch_low, i_address_switch_high, lo, hi;
  logic [6:0] o_station_addr, sta;
  logic [15:0] o_bit_rate;
  logic [15:0] rates[7] = '{RATE_1000, RATE_500, RATE_250, RATE_125, RATE_50, RATE_20, RATE_10};
  logic [DW-1:0] exp_q[$];
  int num_errors = 0;
  int tests_run = 0;
  int n;

  can_station_model i_peer (.o_sync_clk(i_sync_clk));
  can_node_config_status #(.CYC_PER_MS(10), .STATION_DEFAULT(STATION_RST)) i_dut (
    .i_core_clk, .i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_irq, .i_address_switch_low,
    .i_address_switch_high, .i_fast_input_one, .i_fast_input_two, .i_sync_clk, .o_led_red,
    .o_led_green, .i_cycle_start, .i_cycle_end, .i_msg_tx, .o_station_addr, .o_bit_rate,
    .o_master, .o_addr_fault);

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask : tick

  // Request held until waitrequest is seen low; an idle edge follows so no re-drive collides
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      input logic [BEW-1:0] be);
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    do begin
      @(posedge i_core_clk);
    end while (o_avs_waitrequest !== 1'b0);
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_core_clk);
  endtask : xfer

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [3:0] be = 4'hf);
    xfer(1'b1, a, d, be);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, a, '0, '0);
  endtask : rd

  task automatic end_of_test;
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Read data stands at the edge where waitrequest is low
  always @(posedge i_core_clk)
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) check(o_avs_readdata, exp_q.pop_front());

  initial begin
    tick(95000);
    num_errors++;
    end_of_test();
  end

  initial begin
    {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata, i_avs_byteenable} = '0;
    {i_fast_input_one, i_fast_input_two, i_cycle_start, i_cycle_end, i_msg_tx} = '0;
    i_address_switch_low = 4'h0;
    i_address_switch_high = 4'h0;
    i_arst_n = 1'b0;
    void'($urandom(32'h0b30));
    tick(2);
    i_arst_n <= 1'b1;
    tick(1);
    rd(OFF_STATION, 32'(STATION_RST));
    rd(OFF_RATE, 32'(RATE_DEFAULT));
    foreach (rates[i]) begin
      wr(OFF_RATE, 32'(rates[i]));
      rd(OFF_RATE, 32'(rates[i]));
      check(32'(o_bit_rate), 32'(rates[i]));
    end
    // Low lane only: 10 becomes 50
    wr(OFF_RATE, 32'h0000ff32, 4'h1);
    rd(OFF_RATE, 32'(RATE_50));
    wr(OFF_RATE, 32'(16'h0400 | 16'($urandom_range(1023))));
    rd(OFF_RATE, 32'(RATE_DEFAULT));
    // Valid switches, then both zero, then above 127
    sta = STATION_RST;
    for (int k = 0; k < 3; k++) begin
      lo = (k == 1) ? 4'h0 : 4'($urandom);
      hi = (k == 0) ? 4'($urandom_range(7, 1)) : (k == 1) ? 4'h0 : 4'($urandom_range(15, 8));
      i_address_switch_low <= lo;
      i_address_switch_high <= hi;
      tick(4);
      wr(OFF_CTRL, 32'h10);
      if (k == 0) sta = {hi[2:0], lo};
      rd(OFF_STATION, 32'(sta));
      check(32'(o_station_addr), 32'(sta));
    end
    wr(OFF_ROLE, 32'h2);
    tick(2);
    check(32'({o_master, o_addr_fault}), 32'h3);
    wr(OFF_STATION, 32'h1);
    tick(2);
    check(32'({o_master, o_addr_fault}), 32'h2);
    wr(OFF_ROLE, 32'h0);
    tick(2);
    check(32'({o_master, o_addr_fault}), 32'h1);
    for (int v = 1; v >= 0; v--) begin
      wr(OFF_CTRL, 32'(v) << 2);
      tick(2);
      check(32'(o_led_red), 32'(v));
    end
    wr(OFF_CTRL, 32'h1);
    for (int v = 1; v >= 0; v--) begin
      {i_cycle_end, i_cycle_start} <= v ? 2'b10 : 2'b01;
      tick(1);
      {i_cycle_end, i_cycle_start} <= 2'b00;
      tick(3);
      check(32'(o_led_green), 32'(v));
    end
    wr(OFF_CTRL, 32'h8);
    wr(OFF_IRQ_STAT, 32'hf);
    wr(OFF_IRQ_MASK, 32'h1);
    i_fast_input_two <= 1'b1;
    tick(6);
    check(32'(o_irq), 32'h0);
    i_fast_input_one <= 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (o_irq !== 1'b1 && n < 40);
    check(32'(n <= FAST_LAT_CYC), 32'h1);
    wr(OFF_IRQ_STAT, 32'h1);
    check(32'(o_irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h4);
    i_peer.burst(3);
    tick(4);
    check(32'(o_irq), 32'h1);
    wr(OFF_IRQ_STAT, 32'h4);
    check(32'(o_irq), 32'h0);
    // Count green rises inside one period; first state adds one activity pulse
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_NET, 32'(s));
      wr(OFF_CTRL, 32'h2);
      i_msg_tx <= (s == 0);
      @(posedge i_core_clk);
      i_msg_tx <= 1'b0;
      n = 0;
      g = 1'b0;
      repeat (19000) begin
        @(posedge i_core_clk);
        if (o_led_green === 1'b1 && g === 1'b0) n++;
        g = o_led_green;
      end
      check(32'(n), 32'(s + 1 + int'(s == 0)));
    end
    end_of_test();
  end
endmodule : can_node_config_status_bench
